// file: alert_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Shared constants of the alert conditioning block
package alert_pkg;
   // Clock
   localparam int CLK_PERIOD_NS = 20;

   // Register indices; byte address is four times the index
   localparam logic [9:0] CFG_INDEX = 10'h0dd;
   localparam logic [9:0] FORCE_INDEX = 10'h0de;
   localparam logic [9:0] STATUS_INDEX = 10'h0df;

   // Reset values
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [3:0] FORCE_RESET = 4'h0;
   // Writable bits of the configuration word, bit 15 reads zero
   localparam logic [15:0] CFG_MASK = 16'h7fff;

   // Fault channel numbering
   localparam int FAULT_OV = 0;
   localparam int FAULT_UV = 1;
   localparam int FAULT_OC = 2;
   localparam int NUM_FAULTS = 3;

   // Configuration word fields
   localparam int SECOND_RAW_MSB = 14;
   localparam int FIRST_RAW_MSB = 11;
   localparam int OVERCURRENT_FILTER_TIME_LSB = 7;
   localparam int UNDERVOLTAGE_FILTER_TIME_LSB = 5;
   localparam int OVERVOLTAGE_FILTER_TIME_LSB = 3;
   localparam int OC_ON_BIT = 2;
   localparam int OV_ON_BIT = 1;
   localparam int UV_ON_BIT = 0;
   localparam int FIL_LSB [0:2] = '{OVERVOLTAGE_FILTER_TIME_LSB, UNDERVOLTAGE_FILTER_TIME_LSB, OVERCURRENT_FILTER_TIME_LSB};
   localparam int ON_BIT [0:2] = '{OV_ON_BIT, UV_ON_BIT, OC_ON_BIT};

   // Polarity and force word fields
   localparam int SECOND_POL_BIT = 3;
   localparam int FIRST_POL_BIT = 2;
   localparam int SECOND_FORCE_BIT = 1;
   localparam int FIRST_FORCE_BIT = 0;

   // Filter time codes
   localparam logic [1:0] FIL_NONE = 2'h0;
   localparam logic [1:0] FIL_2US = 2'h1;
   localparam logic [1:0] FIL_4US = 2'h2;
   localparam logic [1:0] FIL_8US = 2'h3;

   // Filter times and their least cycle counts, rounded up
   localparam int FIL_2US_NS = 2000;
   localparam int FIL_4US_NS = 4000;
   localparam int FIL_8US_NS = 8000;
   localparam int FIL_2US_CYC =
      (FIL_2US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FIL_4US_CYC =
      (FIL_4US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FIL_8US_CYC =
      (FIL_8US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : alert_pkg
`default_nettype wire

// file: filter_if.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Link between the alert core and one fault filter
interface filter_if;
   logic level;
   logic enable;
   logic [1:0] time_sel;
   logic cond;

   modport ctrl (output level, output enable, output time_sel, input cond);
   modport filt (input level, input enable, input time_sel, output cond);
endinterface : filter_if
`default_nettype wire

// file: fault_filter.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Persistence filter for one comparator result
module fault_filter #(
   parameter int CNT_W = 9
) (
   input wire logic clk_i,
   input wire logic rst_i,
   filter_if.filt chan
);
   logic [CNT_W-1:0] run_count;
   logic [CNT_W-1:0] next_run_count;
   logic [CNT_W-1:0] limit;
   logic fault;
   logic reached;

   // Cycle limit for the selected filter time
   assign limit = (chan.time_sel == alert_pkg::FIL_2US) ?
                     CNT_W'(alert_pkg::FIL_2US_CYC) :
                  (chan.time_sel == alert_pkg::FIL_4US) ?
                     CNT_W'(alert_pkg::FIL_4US_CYC) :
                  (chan.time_sel == alert_pkg::FIL_8US) ?
                     CNT_W'(alert_pkg::FIL_8US_CYC) : '0;
   // A disabled comparator reports no fault
   assign fault = chan.level & chan.enable;
   assign reached = (run_count >= limit);
   // Restart on any drop, saturate at the limit
   assign next_run_count = !fault ? '0 :
                           reached ? run_count :
                           run_count + CNT_W'(1);
   assign chan.cond = fault & reached;

   ////////////////////////////////////////////////////////////////////////
   // Persistence counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_count <= '0;
      end else begin
         run_count <= next_run_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic [CNT_W-1:0] high_len;
   always_ff @(posedge clk_i) begin
      if (rst_i || !fault) begin
         high_len <= '0;
      end else if (!(&high_len)) begin
         high_len <= high_len + CNT_W'(1);
      end
   end

   AST_FILTER_MIN: assert property (@(posedge clk_i) disable iff (rst_i)
      chan.cond |-> (high_len >= limit))
      else $error("conditioned fault passed before filter time");
   AST_FILTER_ZERO: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (chan.time_sel == alert_pkg::FIL_NONE) |-> (chan.cond == fault))
      else $error("zero filter time does not pass fault at once");
   AST_FILTER_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
      (chan.time_sel == alert_pkg::FIL_2US && fault
       && high_len == CNT_W'(alert_pkg::FIL_2US_CYC))
      |-> chan.cond)
      else $error("two microsecond filter failed to pass fault");
   AST_FILTER_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      !chan.enable |-> !chan.cond)
      else $error("disabled comparator reported fault");
   AST_FILTER_RESTART: assert property (@(posedge clk_i)
      disable iff (rst_i)
      !fault |=> (run_count == '0))
      else $error("filter counter did not restart");
   COV_FILTER_8US: cover property (@(posedge clk_i) disable iff (rst_i)
      chan.time_sel == alert_pkg::FIL_8US && $rose(chan.cond));
endmodule : fault_filter
`default_nettype wire

// file: alert_conditioning.sv
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module alert_conditioning #(
   parameter int CNT_W = 9
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ov_fault_i,
   input wire logic uv_fault_i,
   input wire logic oc_fault_i,
   output logic overvoltage_comparator_on_o,
   output logic undervoltage_comparator_on_o,
   output logic overcurrent_comparator_on_o,
   output logic alert_out_first_o,
   output logic alert_out_first_oe_o,
   output logic alert_out_second_o
);
   localparam int NF = alert_pkg::NUM_FAULTS;

   logic [15:0] cfg;
   logic [3:0] force_pol;
   logic [NF-1:0] sync1;
   logic [NF-1:0] sync2;
   logic [NF-1:0] sync3;
   logic [NF-1:0] comp_level;
   logic [NF-1:0] fault_pins;
   logic [NF-1:0] raw_fault;
   logic [NF-1:0] cond_fault;
   logic [NF-1:0] first_pick;
   logic [NF-1:0] second_pick;
   logic [NF-1:0] first_raw_select;
   logic [NF-1:0] second_raw_select;
   logic [NF-1:0] comp_on;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic req;
   logic hit_cfg;
   logic hit_force;
   logic hit_status;
   logic wr_cfg;
   logic wr_force;
   logic [31:0] next_rdata;
   logic [7:0] status_word;
   logic [15:0] next_cfg;
   logic [3:0] next_force_pol;

   // Ack gating keeps a strobe held over the answer from counting twice
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign hit_cfg = (wb_adr_i[11:2] == alert_pkg::CFG_INDEX);
   assign hit_force = (wb_adr_i[11:2] == alert_pkg::FORCE_INDEX);
   assign hit_status = (wb_adr_i[11:2] == alert_pkg::STATUS_INDEX);
   assign wr_cfg = req & wb_we_i & hit_cfg;
   assign wr_force = req & wb_we_i & hit_force & wb_sel_i[0];
   // Byte lanes of the configuration word
   assign next_cfg = {wb_sel_i[1] ? wb_dat_i[15:8] : cfg[15:8],
                      wb_sel_i[0] ? wb_dat_i[7:0] : cfg[7:0]}
                     & alert_pkg::CFG_MASK;
   assign next_force_pol = wb_dat_i[3:0];
   // Status shows live comparator and alert state
   assign status_word = {alert_out_second_o, alert_out_first_oe_o,
                         cond_fault, comp_level};
   // Read mux, unmapped reads return zero
   assign next_rdata = hit_cfg ? {16'h0000, cfg} :
                       hit_force ? {28'h0000000, force_pol} :
                       hit_status ? {24'h000000, status_word} :
                       32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // Acknowledge and read data, one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? next_rdata : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration and polarity/force registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= alert_pkg::CFG_RESET;
      end else if (wr_cfg) begin
         cfg <= next_cfg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         force_pol <= alert_pkg::FORCE_RESET;
      end else if (wr_force) begin
         force_pol <= next_force_pol;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Comparator inputs: three stages, accepted when stages two and three agree
   assign fault_pins = {oc_fault_i, uv_fault_i, ov_fault_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= fault_pins;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comp_level <= '0;
      end else begin
         comp_level <= (sync2 & sync3) | (comp_level & (sync2 | sync3));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One shared filter per comparator, selects per alert channel
   filter_if chan_if [NF] ();

   for (genvar g = 0; g < NF; g++) begin : g_fault
      assign comp_on[g] = cfg[alert_pkg::ON_BIT[g]];
      assign raw_fault[g] = comp_level[g] & comp_on[g];
      assign chan_if[g].level = comp_level[g];
      assign chan_if[g].enable = comp_on[g];
      // Field positions: OV 4..3, UV 6..5, OC 8..7
      assign chan_if[g].time_sel =
         cfg[alert_pkg::FIL_LSB[g] +: 2];
      assign cond_fault[g] = chan_if[g].cond;
      assign first_raw_select[g] = cfg[alert_pkg::FIRST_RAW_MSB - g];
      assign second_raw_select[g] = cfg[alert_pkg::SECOND_RAW_MSB - g];
      // Same filtered result feeds both channels
      assign first_pick[g] =
         first_raw_select[g] ? raw_fault[g] : cond_fault[g];
      assign second_pick[g] =
         second_raw_select[g] ? raw_fault[g] : cond_fault[g];

      fault_filter #(
         .CNT_W(CNT_W)
      ) u_filter (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .chan(chan_if[g].filt)
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Alert activity and pin levels
   logic first_active;
   logic second_active;
   logic first_pol;
   logic second_pol;
   logic first_force;
   logic second_force;

   assign first_pol = force_pol[alert_pkg::FIRST_POL_BIT];
   assign second_pol = force_pol[alert_pkg::SECOND_POL_BIT];
   assign first_force = force_pol[alert_pkg::FIRST_FORCE_BIT];
   assign second_force = force_pol[alert_pkg::SECOND_FORCE_BIT];
   assign first_active = first_force | (|first_pick);
   assign second_active = second_force | (|second_pick);

   // First pin is open drain: drive low only; second is push-pull
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alert_out_first_o <= 1'b0;
         alert_out_first_oe_o <= 1'b0;
         alert_out_second_o <= 1'b1;
      end else begin
         alert_out_first_o <= 1'b0;
         alert_out_first_oe_o <= first_active ^ first_pol;
         alert_out_second_o <= ~(second_active ^ second_pol);
      end
   end

   // Comparator power enables
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overvoltage_comparator_on_o <= 1'b0;
         undervoltage_comparator_on_o <= 1'b0;
         overcurrent_comparator_on_o <= 1'b0;
      end else begin
         overvoltage_comparator_on_o <= cfg[alert_pkg::OV_ON_BIT];
         undervoltage_comparator_on_o <= cfg[alert_pkg::UV_ON_BIT];
         overcurrent_comparator_on_o <= cfg[alert_pkg::OC_ON_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_CFG_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_cfg && wb_sel_i[1:0] == 2'h3)
      |=> (cfg == ($past(wb_dat_i[15:0]) & alert_pkg::CFG_MASK)))
      else $error("configuration write not stored");
   AST_CFG_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i && hit_cfg)
      |=> (wb_ack_o && wb_dat_o[15:0] == $past(cfg)))
      else $error("configuration read back wrong");
   AST_FORCE_FIRST: assert property (@(posedge clk_i)
      disable iff (rst_i)
      first_force |=> (alert_out_first_oe_o != $past(first_pol)))
      else $error("forced first alert not active");
   AST_IDLE_SECOND: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (!second_force && second_pick == 3'h0)
      |=> (alert_out_second_o == !$past(second_pol)))
      else $error("idle second alert at wrong level");
   AST_RAW_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
      (first_raw_select[alert_pkg::FAULT_OV] && raw_fault[alert_pkg::FAULT_OV])
      |=> (alert_out_first_oe_o != $past(first_pol)))
      else $error("raw over-voltage did not reach first alert");
   AST_RAW_SECOND: assert property (@(posedge clk_i) disable iff (rst_i)
      (second_raw_select[alert_pkg::FAULT_OC] && raw_fault[alert_pkg::FAULT_OC])
      |=> (alert_out_second_o == $past(second_pol)))
      else $error("raw over-current did not reach second alert");
   AST_SHARED: assert property (@(posedge clk_i) disable iff (rst_i)
      (cond_fault[alert_pkg::FAULT_UV]
       && !first_raw_select[alert_pkg::FAULT_UV]
       && !second_raw_select[alert_pkg::FAULT_UV])
      |=> (alert_out_first_oe_o != $past(first_pol)
           && alert_out_second_o == $past(second_pol)))
      else $error("shared conditioned fault missed an alert");
   AST_SYNC_DELAY: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(comp_level[alert_pkg::FAULT_OV]) |-> $past(ov_fault_i, 3))
      else $error("comparator accepted without settled input");
   AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");

   // Alert levels for the remaining force and select combinations
   AST_FORCE_SECOND: assert property (@(posedge clk_i)
      disable iff (rst_i)
      second_force |=> (alert_out_second_o == $past(second_pol)))
      else $error("forced second alert not active");
   AST_IDLE_FIRST: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (!first_force && first_pick == 3'h0)
      |=> (alert_out_first_oe_o == $past(first_pol)))
      else $error("idle first alert at wrong level");
   AST_COND_FIRST: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (cond_fault[alert_pkg::FAULT_OC]
       && !first_raw_select[alert_pkg::FAULT_OC])
      |=> (alert_out_first_oe_o != $past(first_pol)))
      else $error("conditioned over-current missed first alert");
   AST_COND_SECOND: assert property (@(posedge clk_i)
      disable iff (rst_i)
      (cond_fault[alert_pkg::FAULT_OV]
       && !second_raw_select[alert_pkg::FAULT_OV])
      |=> (alert_out_second_o == $past(second_pol)))
      else $error("conditioned over-voltage missed second alert");

   // Register bus and enable outputs
   AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !hit_cfg && !hit_force && !hit_status)
      |=> (wb_ack_o && wb_dat_o == 32'h00000000))
      else $error("unmapped access returned data");
   AST_CFG_TOP: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg[15])
      else $error("unused configuration bit set");
   AST_DAT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> (wb_dat_o == 32'h00000000))
      else $error("read data shown without acknowledge");
   AST_COMP_PWR: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ({overcurrent_comparator_on_o, undervoltage_comparator_on_o,
                 overvoltage_comparator_on_o} == $past(comp_on)))
      else $error("comparator enable output does not follow register");

   // Main scenarios
   COV_FORCE: cover property (@(posedge clk_i) disable iff (rst_i)
      $rose(first_force));
   COV_BOTH: cover property (@(posedge clk_i) disable iff (rst_i)
      first_active && second_active && !first_force && !second_force);
   COV_RAW_MIX: cover property (@(posedge clk_i) disable iff (rst_i)
      first_raw_select != second_raw_select && |raw_fault);
endmodule : alert_conditioning
`default_nettype wire

// file: alert_receiver.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Microcontroller interrupt inputs at the far side of both alert pins
module alert_receiver (
   input wire logic first_data_i,
   input wire logic first_oe_i,
   input wire logic second_i,
   input wire logic first_pol_i,
   input wire logic second_pol_i,
   output logic first_pin_o,
   output logic second_pin_o,
   output logic first_active_o,
   output logic second_active_o
);
   // Pull-up holds the open-drain line high while nobody sinks it
   assign first_pin_o = first_oe_i ? first_data_i : 1'b1;
   assign second_pin_o = second_i;
   // Interrupt inputs configured for the same active level
   assign first_active_o = (first_pin_o === first_pol_i);
   assign second_active_o = (second_pin_o === second_pol_i);
endmodule : alert_receiver
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module testbench;
   logic clk_i, rst_i, cyc, stb, we, ack, ov, uv, oc;
   logic [11:0] adr;
   logic [31:0] wdat, dat_o, rd;
   logic [3:0] sel;
   logic ov_on, uv_on, oc_on, a1, a1_oe, a2;
   logic pol1, pol2, pin1, pin2, act1, act2;
   int failures, n_compared, n, lim;
   localparam logic [11:0] CFG = {alert_pkg::CFG_INDEX, 2'h0};
   localparam logic [11:0] FRC = {alert_pkg::FORCE_INDEX, 2'h0};
   localparam logic [11:0] STS = {alert_pkg::STATUS_INDEX, 2'h0};

   alert_conditioning u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .ov_fault_i(ov),
      .uv_fault_i(uv), .oc_fault_i(oc), .overvoltage_comparator_on_o(ov_on),
      .undervoltage_comparator_on_o(uv_on),
      .overcurrent_comparator_on_o(oc_on), .alert_out_first_o(a1),
      .alert_out_first_oe_o(a1_oe), .alert_out_second_o(a2));
   alert_receiver u_rx (.first_data_i(a1), .first_oe_i(a1_oe),
      .second_i(a2), .first_pol_i(pol1), .second_pol_i(pol2),
      .first_pin_o(pin1), .second_pin_o(pin2), .first_active_o(act1),
      .second_active_o(act2));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus and comparison helpers
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wb_cycle(input logic [11:0] a, input logic w,
                           input logic [31:0] d, input logic [3:0] s);
      int k;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rd = dat_o;
      if (k >= 20) check("bus ack", 32'h1, 32'h0);
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
   endtask : wb_cycle

   task automatic rd_chk(input string what, input logic [11:0] a,
                         input logic [31:0] exp);
      wb_cycle(a, 1'b0, 32'h0, 4'hf);
      check(what, exp, rd);
   endtask : rd_chk

   // Counts cycles until the first alert is active, up to a limit
   task automatic wait_act(input int max);
      n = 0;
      while (act1 !== 1'b1 && n < max) begin
         @(posedge clk_i);
         n++;
      end
   endtask : wait_act

   task automatic faults(input logic [2:0] f);
      {oc, uv, ov} <= f;
      @(posedge clk_i);
   endtask : faults

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      rd_chk("cfg reset", CFG, 32'h0);
      rd_chk("force reset", FRC, 32'h0);
      check("idle pins", 32'h3, {pin1, pin2});
      check("comparators off", 32'h0, {oc_on, ov_on, uv_on});
   endtask : t_reset

   task automatic t_regs();
      wb_cycle(CFG, 1'b1, 32'hffff_ffff, 4'h3);
      rd_chk("cfg write", CFG, 32'h7fff);
      check("comparators on", 32'h7, {oc_on, ov_on, uv_on});
      wb_cycle(CFG, 1'b1, 32'h0, 4'h1);
      rd_chk("cfg low lane", CFG, 32'h7f00);
      wb_cycle(12'h100, 1'b1, 32'hffff_ffff, 4'hf);
      rd_chk("unmapped", 12'h100, 32'h0);
      wb_cycle(CFG, 1'b1, 32'h2, 4'h3);
      check("ov on only", 32'h2, {oc_on, ov_on, uv_on});
   endtask : t_regs

   task automatic t_raw();
      for (int f = 0; f < 3; f++) begin
         wb_cycle(CFG, 1'b1, 32'h7fff, 4'h3);
         faults(3'h1 << f);
         wait_act(10);
         check("raw delay", 32'h1, 32'(n <= 8));
         check("raw second", 32'h1, 32'(act2));
         faults(3'h0);
         repeat (8) @(posedge clk_i);
         check("raw release", 32'h0, {act1, act2});
      end
      wb_cycle(CFG, 1'b1, 32'h7ff8, 4'h3);
      faults(3'h7);
      wait_act(20);
      check("disabled", 32'h0, {act1, act2});
      faults(3'h0);
      // Let the released comparators settle before the selects change
      repeat (8) @(posedge clk_i);
      wb_cycle(CFG, 1'b1, 32'h0fff, 4'h3);
      faults(3'h1);
      wait_act(10);
      check("split select", 32'h2, {act1, act2});
      faults(3'h0);
      repeat (8) @(posedge clk_i);
   endtask : t_raw

   task automatic t_filter();
      for (int c = 0; c < 4; c++) begin
         lim = (c == 0) ? 0 : (c == 1) ? alert_pkg::FIL_2US_CYC :
            (c == 2) ? alert_pkg::FIL_4US_CYC : alert_pkg::FIL_8US_CYC;
         wb_cycle(CFG, 1'b1, 32'h7 | (c << alert_pkg::FIL_LSB[c % 3]), 4'h3);
         if (c > 0) begin
            faults(3'h1 << (c % 3));
            wait_act(lim - 8);
            check("short event blocked", 32'h0, 32'(act1));
            faults(3'h0);
            repeat (2) @(posedge clk_i);
         end
         faults(3'h1 << (c % 3));
         wait_act(lim + 12);
         check("filter low", 32'h1, 32'(n >= lim + 4));
         check("filter high", 32'h1, 32'(n <= lim + 6));
         check("shared filter", 32'h1, 32'(act2));
         rd_chk("status", STS, 32'h40 | (32'h9 << (c % 3)));
         faults(3'h0);
         repeat (8) @(posedge clk_i);
      end
      wb_cycle(CFG, 1'b1, 32'h0, 4'h3);
   endtask : t_filter

   task automatic t_polforce();
      wb_cycle(FRC, 1'b1, 32'hc, 4'h1);
      pol1 <= 1'b1; pol2 <= 1'b1;
      repeat (2) @(posedge clk_i);
      check("high idle pins", 32'h0, {pin1, pin2});
      wb_cycle(FRC, 1'b1, 32'hd, 4'h1);
      repeat (2) @(posedge clk_i);
      check("force first", 32'h2, {act1, act2});
      wb_cycle(FRC, 1'b1, 32'h2, 4'h1);
      pol1 <= 1'b0; pol2 <= 1'b0;
      repeat (2) @(posedge clk_i);
      check("force second", 32'h1, {act1, act2});
      check("force pins", 32'h2, {pin1, pin2});
      rd_chk("force readback", FRC, 32'h2);
   endtask : t_polforce

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   initial begin
      #400000;
      failures++;
      wrap_up();
   end

   initial begin
      failures = 0; n_compared = 0;
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h0;
      wdat = 32'h0; sel = 4'h0; ov = 1'b0; uv = 1'b0; oc = 1'b0;
      pol1 = 1'b0; pol2 = 1'b0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_regs();
      t_raw();
      t_filter();
      t_polforce();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
